/* inc/mwl_regs.svh */
// Register map and constants of the load unit
`ifndef MWL_REGS_SVH
`define MWL_REGS_SVH
`define MWL_AXI_AW 8
`define MWL_OFS_CTRL 8'h00
`define MWL_OFS_STATUS 8'h04
`define MWL_OFS_COUNT 8'h08
`define MWL_OFS_FAULT 8'h0C
`define MWL_CTRL_W 5
`define MWL_CTRL_RST 5'h00
`define MWL_CTRL_V6 0
`define MWL_CTRL_ALIGN 1
`define MWL_CTRL_UNALIGN 2
`define MWL_CTRL_MOD8 3
`define MWL_CTRL_BE32 4
`define MWL_STAT_BUSY 0
`define MWL_STAT_UNDEF 1
`define MWL_STAT_ABORT 2
`define MWL_STAT_ALIGN 3
`define MWL_COND_AL 4'hE
`define MWL_WORD_STEP 32'h0000_0004
`define MWL_RESP_OK 2'h0
`define MWL_RESP_SLVERR 2'h2
`endif

/* inc/mwl_pkg.sv */
// Types shared by the load unit and its helpers
package mwl_pkg;
`include "mwl_regs.svh"

   typedef enum logic [3:0] {
      OP_PAIR = 4'h1,
      OP_EXCL = 4'h2,
      OP_HALF = 4'h4,
      OP_SBYTE = 4'h8
   } mwl_op_t;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_HALF = 2'h1,
      SZ_WORD = 2'h2
   } mwl_size_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_REQ = 4'h2,
      S_RSP = 4'h4,
      S_FIN = 4'h8
   } mwl_st_t;

   typedef struct packed {
      mwl_op_t op;
      logic [3:0] cond;
      logic [3:0] nzcv;
      logic eBit;
      logic [3:0] rd;
      logic [3:0] baseReg;
      logic wbEn;
      logic [31:0] addr;
      logic [31:0] wbAddr;
      logic [31:0] physAddr;
      logic shareable;
   } mwl_issue_t;

   typedef struct packed {
      logic [31:0] addr;
      mwl_size_t size;
      logic bigEnd;
   } mwl_mem_req_t;

   typedef struct packed {
      logic en;
      logic [3:0] idx;
      logic [31:0] data;
   } mwl_gpr_wr_t;

   typedef struct packed {
      logic [31:0] addr;
      logic shared;
   } mwl_mon_t;

   typedef struct packed {
      mwl_st_t st;
      mwl_issue_t req;
      logic issueRdy;
      logic word;
      logic [31:0] loData;
      logic memValid;
      mwl_mem_req_t mem;
      mwl_gpr_wr_t gprA;
      mwl_gpr_wr_t gprB;
      mwl_gpr_wr_t baseWr;
      logic monValid;
      mwl_mon_t mon;
      logic undef;
      logic abort;
      logic align;
      logic done;
      logic skip;
      logic [`MWL_CTRL_W-1:0] ctrl;
      logic undefSeen;
      logic abortSeen;
      logic alignSeen;
      logic [31:0] count;
      logic [31:0] faultAddr;
      logic awRdy;
      logic wRdy;
      logic awHeld;
      logic wHeld;
      logic [`MWL_AXI_AW-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } mwl_unit_state_t;
endpackage

/* logic/mwl_cond_check.sv */
// Condition field evaluation against the status flags
`timescale 1ns/1ps
module mwl_cond_check
   import mwl_pkg::*;
(
   // Condition and flags
   input wire logic [3:0] cond,
   input wire logic [3:0] nzcv,
   // Verdict
   output logic pass
);
   logic n, z, c, v;
   assign {n, z, c, v} = nzcv;

   // Standard sixteen-way condition table; the never code fails
   always_comb
   begin
      case (cond)
         4'h0: pass = z;
         4'h1: pass = !z;
         4'h2: pass = c;
         4'h3: pass = !c;
         4'h4: pass = n;
         4'h5: pass = !n;
         4'h6: pass = v;
         4'h7: pass = !v;
         4'h8: pass = c && !z;
         4'h9: pass = !c || z;
         4'hA: pass = n == v;
         4'hB: pass = n != v;
         4'hC: pass = !z && (n == v);
         4'hD: pass = z || (n != v);
         `MWL_COND_AL: pass = 1'b1;
         default: pass = 1'b0;
      endcase
   end
endmodule

/* logic/mwl_load_extend.sv */
// Byte lane selection, byte order and extension of a loaded word
`timescale 1ns/1ps
module mwl_load_extend
   import mwl_pkg::*;
(
   // Raw data and access shape
   input wire logic [31:0] word,
   input wire logic [1:0] lowAddr,
   input wire mwl_size_t size,
   input wire logic signExt,
   input wire logic bigEnd,
   input wire logic wordInv,
   // Register value
   output logic [31:0] result
);
   function automatic logic [7:0] laneByte(logic [31:0] w, logic [1:0] lane);
      laneByte = w[8*lane +: 8];
   endfunction

   logic [1:0] lane;
   logic [15:0] half;
   logic [7:0] byt;

   // Word-invariant mode flips lanes; byte-invariant mode swaps bytes
   always_comb
   begin
      lane = wordInv ? (lowAddr ^ 2'h3) : lowAddr;
      byt = laneByte(word, lane);
      if (wordInv)
         half = lowAddr[1] ? word[15:0] : word[31:16];
      else if (bigEnd)
         half = {laneByte(word, lowAddr), laneByte(word, lowAddr + 2'h1)};
      else
         half = {laneByte(word, lowAddr + 2'h1), laneByte(word, lowAddr)};
      case (size)
         SZ_BYTE: result = {{24{signExt & byt[7]}}, byt};
         SZ_HALF: result = {16'h0000, half};
         default: result = bigEnd ? {word[7:0], word[15:8], word[23:16], word[31:24]}
                                  : word;
      endcase
   end
endmodule

/* logic/mwl_load_unit.sv */
// Load unit for pair, exclusive, unsigned half and signed byte loads
//
// What this block does
// - Pair load with odd first destination raises undefined instruction.
// - Lower word goes to even register, upper word to the next odd.
// - Upper word address is the lower address plus four.
// - Before version 6, misaligned pair data is undefined; trap optional.
// - From version 6, pair alignment check at four or eight bytes.
// - The two pair word accesses may go in any order.
// - Exclusive load reads a word, marks shared monitor when shareable.
// - Every exclusive load that completes without an abort marks the local monitor.
// - Aborted exclusive load leaves its destination unchanged.
// - Exclusive load needs low two address bits zero.
// - Unsigned half load zero-extends sixteen bits to a word.
// - Before version 6, odd half address may take a data abort.
// - Signed byte load sign-extends its byte to a word.
// - Each load runs only when its condition passes.
// - From version 6, byte order follows the status word endian flag.
`timescale 1ns/1ps
module mwl_load_unit
   import mwl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Instruction issue
   input wire logic issueValid,
   input wire mwl_issue_t issueReq,
   output logic issueReady,
   // Memory load path
   output logic memReqValid,
   output mwl_mem_req_t memReq,
   input wire logic memReqReady,
   input wire logic memRspValid,
   input wire logic [31:0] memRspData,
   input wire logic memRspAbort,
   // Exclusive monitors
   output logic monMarkValid,
   output mwl_mon_t monMark,
   // Register file writes
   output mwl_gpr_wr_t gprWrA,
   output mwl_gpr_wr_t gprWrB,
   output mwl_gpr_wr_t baseWr,
   // Completion and exceptions
   output logic loadDone,
   output logic condSkip,
   output logic undefInstr,
   output logic dataAbort,
   output logic alignFault,
   // AXI4-Lite write channels
   input wire logic awvalid,
   output logic awready,
   input wire logic [`MWL_AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read channels
   input wire logic arvalid,
   output logic arready,
   input wire logic [`MWL_AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   mwl_unit_state_t s, n;
   logic condPass;
   logic [31:0] extData;
   logic v6;

   assign v6 = s.ctrl[`MWL_CTRL_V6];

   // Size of the access for each load kind
   function automatic mwl_size_t opSize(mwl_op_t op);
      case (op)
         OP_HALF: opSize = SZ_HALF;
         OP_SBYTE: opSize = SZ_BYTE;
         default: opSize = SZ_WORD;
      endcase
   endfunction

   // Alignment trap for one load
   function automatic logic misTrap(mwl_op_t op, logic [31:0] a,
                                    logic [`MWL_CTRL_W-1:0] c);
      logic chk;
      chk = c[`MWL_CTRL_ALIGN];
      case (op)
         OP_EXCL: misTrap = a[1:0] != 2'h0;
         OP_HALF: misTrap = chk && a[0];
         OP_PAIR:
         begin
            if (c[`MWL_CTRL_V6] && !c[`MWL_CTRL_MOD8])
               misTrap = chk && (a[1:0] != 2'h0);
            else
               misTrap = chk && (a[2:0] != 3'h0);
         end
         default: misTrap = 1'b0;
      endcase
   endfunction

   // Register file read mux
   function automatic logic [31:0] regRead(mwl_unit_state_t q, logic [`MWL_AXI_AW-1:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == `MWL_OFS_CTRL)
         d[`MWL_CTRL_W-1:0] = q.ctrl;
      else if (a == `MWL_OFS_STATUS)
      begin
         d[`MWL_STAT_BUSY] = !q.issueRdy;
         d[`MWL_STAT_UNDEF] = q.undefSeen;
         d[`MWL_STAT_ABORT] = q.abortSeen;
         d[`MWL_STAT_ALIGN] = q.alignSeen;
      end
      else if (a == `MWL_OFS_COUNT)
         d = q.count;
      else if (a == `MWL_OFS_FAULT)
         d = q.faultAddr;
      regRead = d;
   endfunction

   function automatic logic regMapped(logic [`MWL_AXI_AW-1:0] a);
      regMapped = (a == `MWL_OFS_CTRL) || (a == `MWL_OFS_STATUS) ||
                  (a == `MWL_OFS_COUNT) || (a == `MWL_OFS_FAULT);
   endfunction

   // Condition check on the issued load
   mwl_cond_check u_cond (
      .cond(issueReq.cond),
      .nzcv(issueReq.nzcv),
      .pass(condPass)
   );

   // Lane and extension of the answered word
   mwl_load_extend u_ext (
      .word(memRspData),
      .lowAddr(s.mem.addr[1:0]),
      .size(s.mem.size),
      .signExt(s.req.op == OP_SBYTE),
      .bigEnd(s.mem.bigEnd),
      .wordInv(!v6 && s.ctrl[`MWL_CTRL_BE32]),
      .result(extData)
   );

   // Next state of sequencer and register slave
   always_comb
   begin
      n = s;
      n.gprA.en = 1'b0;
      n.gprB.en = 1'b0;
      n.baseWr.en = 1'b0;
      n.monValid = 1'b0;
      n.undef = 1'b0;
      n.abort = 1'b0;
      n.align = 1'b0;
      n.done = 1'b0;
      n.skip = 1'b0;

      case (s.st)
         S_IDLE:
         begin
            if (issueValid && s.issueRdy)
            begin
               n.req = issueReq;
               n.issueRdy = 1'b0;
               n.word = 1'b0;
               n.st = S_FIN;
               if (!condPass)
                  n.skip = 1'b1;
               else if (issueReq.op == OP_PAIR && issueReq.rd[0])
                  n.undef = 1'b1;
               else if (misTrap(issueReq.op, issueReq.addr, s.ctrl))
               begin
                  n.abort = 1'b1;
                  n.align = 1'b1;
                  n.faultAddr = issueReq.addr;
               end
               else
               begin
                  // Version 6 byte order from the status word
                  n.memValid = 1'b1;
                  n.mem.addr = issueReq.addr;
                  n.mem.size = opSize(issueReq.op);
                  n.mem.bigEnd = v6 && issueReq.eBit;
                  n.st = S_REQ;
               end
            end
         end
         S_REQ:
         begin
            if (memReqReady)
            begin
               n.memValid = 1'b0;
               n.st = S_RSP;
            end
         end
         S_RSP:
         begin
            if (memRspValid)
            begin
               if (memRspAbort)
               begin
                  // Nothing is written back or marked after an abort
                  n.abort = 1'b1;
                  n.faultAddr = s.mem.addr;
                  n.st = S_FIN;
               end
               else if (s.req.op == OP_PAIR && !s.word)
               begin
                  // Lower word first, then upper; order is free
                  n.loData = extData;
                  n.word = 1'b1;
                  n.memValid = 1'b1;
                  n.mem.addr = s.req.addr + `MWL_WORD_STEP;
                  n.st = S_REQ;
               end
               else
               begin
                  n.gprA.en = 1'b1;
                  if (s.req.op == OP_PAIR)
                  begin
                     // Both halves land together so an abort on the upper
                     // word leaves the pair untouched
                     n.gprA.idx = {s.req.rd[3:1], 1'b0};
                     n.gprA.data = s.loData;
                     n.gprB.en = 1'b1;
                     n.gprB.idx = {s.req.rd[3:1], 1'b1};
                     n.gprB.data = extData;
                  end
                  else
                  begin
                     n.gprA.idx = s.req.rd;
                     n.gprA.data = extData;
                  end
                  if (s.req.op == OP_EXCL)
                  begin
                     n.monValid = 1'b1;
                     n.mon.addr = s.req.physAddr;
                     n.mon.shared = s.req.shareable;
                  end
                  else if (s.req.wbEn)
                  begin
                     n.baseWr.en = 1'b1;
                     n.baseWr.idx = s.req.baseReg;
                     n.baseWr.data = s.req.wbAddr;
                  end
                  n.done = 1'b1;
                  n.count = s.count + 32'h0000_0001;
                  n.st = S_FIN;
               end
            end
         end
         S_FIN:
         begin
            n.issueRdy = 1'b1;
            n.st = S_IDLE;
         end
         default:
         begin
            n.st = S_IDLE;
            n.issueRdy = 1'b1;
         end
      endcase

      // Register writes; address and data in either order
      if (awvalid && s.awRdy)
      begin
         n.awHeld = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && s.wRdy)
      begin
         n.wHeld = 1'b1;
         n.wData = wdata;
         n.wStrb = wstrb;
      end
      if (s.bValid && bready)
         n.bValid = 1'b0;
      if (s.awHeld && s.wHeld && !s.bValid)
      begin
         n.awHeld = 1'b0;
         n.wHeld = 1'b0;
         n.bValid = 1'b1;
         n.bResp = regMapped(s.awAddr) ? `MWL_RESP_OK : `MWL_RESP_SLVERR;
         if (s.awAddr == `MWL_OFS_CTRL && s.wStrb[0])
            n.ctrl = s.wData[`MWL_CTRL_W-1:0];
         else if (s.awAddr == `MWL_OFS_STATUS && s.wStrb[0])
         begin
            // Write one to clear the sticky flags
            n.undefSeen = s.undefSeen && !s.wData[`MWL_STAT_UNDEF];
            n.abortSeen = s.abortSeen && !s.wData[`MWL_STAT_ABORT];
            n.alignSeen = s.alignSeen && !s.wData[`MWL_STAT_ALIGN];
         end
      end
      // Set after clear, so a same-cycle event wins
      if (n.undef)
         n.undefSeen = 1'b1;
      if (n.abort)
         n.abortSeen = 1'b1;
      if (n.align)
         n.alignSeen = 1'b1;
      n.awRdy = !n.awHeld && !n.bValid;
      n.wRdy = !n.wHeld && !n.bValid;

      // Register read side, one read at a time
      if (arvalid && s.arRdy)
      begin
         n.rValid = 1'b1;
         n.rData = regRead(s, araddr);
         n.rResp = regMapped(araddr) ? `MWL_RESP_OK : `MWL_RESP_SLVERR;
      end
      else if (s.rValid && rready)
         n.rValid = 1'b0;
      n.arRdy = !n.rValid;
   end

   // One state register for the unit
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s <= '0;
         s.st <= S_IDLE;
         s.issueRdy <= 1'b1;
         s.ctrl <= `MWL_CTRL_RST;
         s.awRdy <= 1'b1;
         s.wRdy <= 1'b1;
         s.arRdy <= 1'b1;
      end
      else
         s <= n;
   end

   // Outputs straight from the state register
   assign issueReady = s.issueRdy;
   assign memReqValid = s.memValid;
   assign memReq = s.mem;
   assign monMarkValid = s.monValid;
   assign monMark = s.mon;
   assign gprWrA = s.gprA;
   assign gprWrB = s.gprB;
   assign baseWr = s.baseWr;
   assign loadDone = s.done;
   assign condSkip = s.skip;
   assign undefInstr = s.undef;
   assign dataAbort = s.abort;
   assign alignFault = s.align;
   assign awready = s.awRdy;
   assign wready = s.wRdy;
   assign bvalid = s.bValid;
   assign bresp = s.bResp;
   assign arready = s.arRdy;
   assign rvalid = s.rValid;
   assign rdata = s.rData;
   assign rresp = s.rResp;
endmodule

/* tb/mwl_load_unit_props.sv */
// Concurrent checks on the load unit ports
`timescale 1ns/1ps
module mwl_load_unit_props
   import mwl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Issue and memory
   input wire logic issueValid,
   input wire mwl_issue_t issueReq,
   input wire logic issueReady,
   input wire logic memReqValid,
   input wire mwl_mem_req_t memReq,
   input wire logic memReqReady,
   // Results
   input wire logic monMarkValid,
   input wire mwl_mon_t monMark,
   input wire mwl_gpr_wr_t gprWrA,
   input wire mwl_gpr_wr_t gprWrB,
   input wire mwl_gpr_wr_t baseWr,
   input wire logic loadDone,
   input wire logic condSkip,
   input wire logic undefInstr,
   input wire logic dataAbort,
   input wire logic alignFault
);
   logic take;
   mwl_issue_t cur_q;
   logic [31:0] first_q;
   logic [1:0] acc_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   assign take = issueValid && issueReady;
   // Last taken load and its accepted accesses
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cur_q <= '0;
         first_q <= 32'h0;
         acc_q <= 2'h0;
      end
      else if (take)
      begin
         cur_q <= issueReq;
         acc_q <= 2'h0;
      end
      else if (memReqValid && memReqReady)
      begin
         first_q <= memReq.addr;
         acc_q <= acc_q + 2'h1;
      end
   end
   odd_pair_undef_a: assert property (
      take && issueReq.op == OP_PAIR && issueReq.rd[0] && issueReq.cond == 4'hE
      |=> undefInstr && !memReqValid) else $error("odd pair ran");
   pair_regs_a: assert property (
      gprWrB.en |-> gprWrA.en && gprWrA.idx == (cur_q.rd & 4'hE)
      && gprWrB.idx == (cur_q.rd | 4'h1)) else $error("pair regs");
   upper_addr_a: assert property (
      memReqValid && memReqReady && cur_q.op == OP_PAIR && acc_q == 2'h1
      |-> memReq.addr == first_q + 32'h4) else $error("upper addr");
   excl_mark_a: assert property (
      monMarkValid |-> cur_q.op == OP_EXCL && gprWrA.en && monMark.addr == cur_q.physAddr
      && monMark.shared == cur_q.shareable) else $error("bad mark");
   excl_word_a: assert property (
      memReqValid && cur_q.op == OP_EXCL |-> memReq.size == SZ_WORD
      && memReq.addr == cur_q.addr) else $error("excl shape");
   half_zero_a: assert property (
      gprWrA.en && cur_q.op == OP_HALF |-> gprWrA.data[31:16] == 16'h0)
      else $error("half extend");
   byte_sign_a: assert property (
      gprWrA.en && cur_q.op == OP_SBYTE |-> gprWrA.data[31:8] == {24{gprWrA.data[7]}})
      else $error("byte extend");
   skip_quiet_a: assert property (
      take && issueReq.cond == 4'h0 && issueReq.nzcv == 4'h0 |=> condSkip
      ##1 (!memReqValid && !gprWrA.en && !baseWr.en)) else $error("skip ran");
   abort_quiet_a: assert property (
      dataAbort |-> !gprWrA.en && !monMarkValid && !baseWr.en && !loadDone)
      else $error("abort wrote");
   excl_align_a: assert property (
      take && issueReq.op == OP_EXCL && issueReq.cond == 4'hE && issueReq.addr[1:0] != 2'h0
      |=> dataAbort && alignFault && !memReqValid) else $error("excl misalign");
   byte_issue_a: assert property (
      take && issueReq.cond == 4'hE && issueReq.op == OP_SBYTE |=> memReqValid
      && memReq.addr == $past(issueReq.addr)) else $error("byte not issued");
   cover property (loadDone && gprWrB.en);
   cover property (monMarkValid && monMark.shared);
   cover property (dataAbort && alignFault);
endmodule
bind mwl_load_unit mwl_load_unit_props chk (.clk, .arst_n, .issueValid, .issueReq,
   .issueReady, .memReqValid, .memReq, .memReqReady, .monMarkValid, .monMark, .gprWrA,
   .gprWrB, .baseWr, .loadDone, .condSkip, .undefInstr, .dataAbort, .alignFault);

/* tb/mwl_mem_model.sv */
// Behavioural memory with prompt or slow answers
`timescale 1ns/1ps
module mwl_mem_model
   import mwl_pkg::*;
(
   // Clock, reset and pace
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slow,
   // Load path
   input wire logic memReqValid,
   input wire mwl_mem_req_t memReq,
   output logic memReqReady,
   output logic memRspValid,
   output logic [31:0] memRspData,
   output logic memRspAbort,
   // Observation
   output int nReq,
   output logic lastBig,
   output logic [31:0] prevAddr,
   output logic [31:0] lastAddr
);
   logic pend_q, tog_q;
   logic [1:0] wait_q;
   // Slow mode offers ready only every other cycle
   assign memReqReady = !pend_q && (!slow || tog_q);
   // One access at a time; either order of words is accepted
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         {pend_q, tog_q, wait_q, lastBig, memRspValid, memRspAbort} <= 7'h0;
         nReq <= 0;
         prevAddr <= 32'h0;
         lastAddr <= 32'h0;
         memRspData <= 32'h0;
      end
      else
      begin
         tog_q <= !tog_q;
         memRspValid <= 1'h0;
         // Idle lines flip so stale data never passes for an answer
         memRspData <= ~memRspData;
         memRspAbort <= ~memRspAbort;
         if (memReqValid && memReqReady)
         begin
            pend_q <= 1'h1;
            wait_q <= slow ? 2'h3 : 2'h0;
            nReq <= nReq + 1;
            lastBig <= memReq.bigEnd;
            prevAddr <= lastAddr;
            lastAddr <= memReq.addr;
         end
         else if (pend_q && wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
         else if (pend_q)
         begin
            pend_q <= 1'h0;
            memRspValid <= 1'h1;
            memRspData <= {lastAddr[31:2], 2'h0} + 32'h8070_6050;
            memRspAbort <= lastAddr[31:28] == 4'hF;
         end
      end
   end
endmodule

/* tb/mwl_load_unit_test.sv */
// Self-checking bench for the load unit
`timescale 1ns/1ps
module mwl_load_unit_test
   import mwl_pkg::*;
;
   logic clk = 1'h0, arst_n = 1'h0, slow = 1'h0, eb = 1'h0, issueValid = 1'h0, mV;
   logic issueReady, memReqValid, memReqReady, memRspValid, memRspAbort, lastBig;
   logic monMarkValid, loadDone, condSkip, undefInstr, dataAbort, alignFault;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, memRspData, rdata, prevAddr, lastAddr;
   logic [3:0] wstrb = 4'hF, kind;
   logic [1:0] bresp, rresp, resp;
   mwl_issue_t issueReq = '0;
   mwl_mem_req_t memReq;
   mwl_mon_t monMark, mk;
   mwl_gpr_wr_t gprWrA, gprWrB, baseWr, gA, gB, bW;
   int mismatches = 0, nChecks = 0, nReq, nDone = 0, r0;
   mwl_load_unit uut (.clk, .arst_n, .issueValid, .issueReq, .issueReady, .memReqValid,
      .memReq, .memReqReady, .memRspValid, .memRspData, .memRspAbort, .monMarkValid,
      .monMark, .gprWrA, .gprWrB, .baseWr, .loadDone, .condSkip, .undefInstr, .dataAbort,
      .alignFault, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
   mwl_mem_model mem (.clk, .arst_n, .slow, .memReqValid, .memReq, .memReqReady,
      .memRspValid, .memRspData, .memRspAbort, .nReq, .lastBig, .prevAddr, .lastAddr);
   always #5 clk = ~clk;
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Issue one load, gather its pulses; base 9 is never a destination
   task automatic load(mwl_op_t op, logic [3:0] cnd, logic [3:0] rd, logic [31:0] a, logic sh);
      @(posedge clk);
      issueValid <= 1'h1;
      issueReq <= '{op, cnd, 4'h0, eb, rd, 4'h9, op != OP_EXCL,
         a, a + 32'h8, a + 32'h1000, sh};
      @(negedge clk);
      while (issueReady !== 1'h1) @(negedge clk);
      @(posedge clk);
      issueValid <= 1'h0;
      {gA, gB, bW, mk, mV, kind} = '0;
      r0 = nReq;
      while (kind == 4'h0)
      begin
         @(negedge clk);
         if (gprWrA.en === 1'h1) gA = gprWrA;
         if (gprWrB.en === 1'h1) gB = gprWrB;
         if (baseWr.en === 1'h1) bW = baseWr;
         if (monMarkValid === 1'h1) {mV, mk} = {1'h1, monMark};
         kind = {loadDone, condSkip, undefInstr, dataAbort};
      end
      if (loadDone === 1'h1) nDone++;
   endtask
   // Each channel holds valid until its own handshake
   task automatic axw(logic [7:0] a, logic [31:0] d);
      logic ha, hw, hb;
      @(posedge clk);
      {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
      do
      begin
         @(negedge clk);
         {ha, hw, hb, resp} = {awvalid && awready, wvalid && wready, bvalid, bresp};
         @(posedge clk);
         if (ha) awvalid <= 1'h0;
         if (hw) wvalid <= 1'h0;
         if (hb) bready <= 1'h0;
      end
      while (!hb);
   endtask
   task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
      logic ha, hr;
      logic [31:0] v;
      @(posedge clk);
      {arvalid, rready, araddr} <= {2'h3, a};
      do
      begin
         @(negedge clk);
         {ha, hr, v, resp} = {arvalid && arready, rvalid, rdata, rresp};
         @(posedge clk);
         if (ha) arvalid <= 1'h0;
         if (hr) rready <= 1'h0;
      end
      while (!hr);
      chk(nm, v, exp);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", nChecks, mismatches);
      if (mismatches == 0 && nChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Ends a hang well past the expected run
   initial
   begin
      #200000;
      mismatches++;
      conclude();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      arst_n <= 1'h1;
      // Plain loads, pre-version-6 little-endian, no alignment check
      rchk("ctrl reset", 8'h00, 32'h0);
      load(OP_SBYTE, 4'hE, 4'h2, 32'h103, 1'h0);
      chk("sbyte neg", gA.data, 32'hFFFF_FF80);
      load(OP_SBYTE, 4'hE, 4'h2, 32'h100, 1'h0);
      chk("sbyte pos", gA.data, 32'h0000_0050);
      eb <= 1'h1;
      load(OP_HALF, 4'hE, 4'h3, 32'h102, 1'h0);
      chk("half data", gA.data, 32'h0000_8070);
      chk("half order", {31'h0, lastBig}, 32'h0);
      eb <= 1'h0;
      load(OP_PAIR, 4'hE, 4'h4, 32'h100, 1'h0);
      chk("pair lo", {gA.idx, gA.data}, {4'h4, 32'h8070_6150});
      chk("pair hi", {gB.idx, gB.data}, {4'h5, 32'h8070_6154});
      chk("pair addr", lastAddr - prevAddr, 32'h4);
      chk("pair wb", bW.data, 32'h108);
      load(OP_PAIR, 4'hE, 4'h5, 32'h100, 1'h0);
      chk("odd rd", {28'h0, kind}, 32'h2);
      chk("odd rd acc", 32'(nReq - r0), 32'h0);
      load(OP_PAIR, 4'h0, 4'h4, 32'h100, 1'h0);
      chk("cond fail", {28'h0, kind}, 32'h4);
      chk("fail quiet", 32'(nReq - r0) | bW.en, 32'h0);
      load(OP_HALF, 4'h1, 4'h3, 32'h100, 1'h0);
      chk("cond pass", {28'h0, kind}, 32'h8);
      $display("test basic done");
      // Exclusive loads: shared and local marks, misalignment, memory abort
      load(OP_EXCL, 4'hE, 4'h6, 32'h200, 1'h1);
      chk("excl data", gA.data, 32'h8070_6250);
      chk("excl mark", {mk.shared, mk.addr}, {1'h1, 32'h1200});
      load(OP_EXCL, 4'hE, 4'h6, 32'h200, 1'h0);
      chk("local mark", {mV, mk.shared}, 32'h2);
      load(OP_EXCL, 4'hE, 4'h6, 32'h202, 1'h1);
      chk("excl align", {28'h0, kind}, 32'h1);
      chk("align acc", 32'(nReq - r0), 32'h0);
      load(OP_EXCL, 4'hE, 4'h6, 32'hF000_0200, 1'h1);
      chk("excl abort", {mV, gA.en, kind}, 32'h1);
      rchk("fault", 8'h0C, 32'hF000_0200);
      $display("test exclusive done");
      // Alignment checks before and from version 6
      axw(8'h00, 32'h02);
      load(OP_HALF, 4'hE, 4'h3, 32'h101, 1'h0);
      chk("odd half", {28'h0, kind}, 32'h1);
      load(OP_PAIR, 4'hE, 4'h4, 32'h104, 1'h0);
      chk("pair mod8 old", {28'h0, kind}, 32'h1);
      axw(8'h00, 32'h03);
      slow <= 1'h1;
      load(OP_PAIR, 4'hE, 4'h4, 32'h104, 1'h0);
      chk("pair mod4", {gB.data, prevAddr}, {32'h8070_6158, 32'h104});
      eb <= 1'h1;
      load(OP_HALF, 4'hE, 4'h3, 32'h100, 1'h0);
      chk("v6 order", {15'h0, lastBig, gA.data[15:0]}, 32'h0001_5061);
      slow <= 1'h0;
      axw(8'h00, 32'h0B);
      load(OP_PAIR, 4'hE, 4'h4, 32'h104, 1'h0);
      chk("pair mod8", {28'h0, kind}, 32'h1);
      rchk("ctrl", 8'h00, 32'h0B);
      rchk("status", 8'h04, 32'h0E);
      axw(8'h04, 32'h0E);
      rchk("status clr", 8'h04, 32'h0);
      rchk("count", 8'h08, 32'(nDone));
      rchk("unmapped", 8'h10, 32'h0);
      chk("unmapped resp", {30'h0, resp}, 32'h2);
      $display("test registers done");
      conclude();
   end
endmodule
